/* File: rtl/fc_regs.svh */
`ifndef FC_REGS_SVH
`define FC_REGS_SVH
`define FC_ADDR_MASTER 3'h0
`define FC_ADDR_FLASH 3'h1
`define FC_ADDR_TORCH 3'h2
`define FC_RST_MASTER 8'h00
`define FC_RST_FLASH 8'hE0
`define FC_RST_TORCH 8'h00
`define FC_BIT_ON 3
`define FC_BIT_SHORT 2
`define FC_BIT_OPEN 1
`define FC_BIT_TSD 0
`define FC_TMO_HI 7
`define FC_TMO_LO 5
`define FC_BIT_FLASH_REQ 4
`define FC_BIT_TORCH_REQ 4
`define FC_BIT_TORCH_INH 7
`define FC_CUR_HI 3
`define FC_CUR_LO 0
`define FC_SLAVE_ADDR 7'h5A
`define FC_BYTE_BITS 4'h8
`define FC_CLK_KHZ 10000
`define FC_US_PER_MS 1000
`define FC_ENABLE_LOW_MS 1000
`define FC_TMO_STEP_US 156250
`define FC_TMO_CODES 8
`define FC_NUM_PINS 10
`define FC_PIN_IDLE 10'h300
`endif

/* File: rtl/fc_pkg.sv */
package fc_pkg;
  typedef enum logic [8:0] {
    FC_I2C_IDLE = 9'b000000001,
    FC_I2C_ADDR = 9'b000000010,
    FC_I2C_ADDR_ACK = 9'b000000100,
    FC_I2C_REG = 9'b000001000,
    FC_I2C_REG_ACK = 9'b000010000,
    FC_I2C_WDATA = 9'b000100000,
    FC_I2C_WDATA_ACK = 9'b001000000,
    FC_I2C_RDATA = 9'b010000000,
    FC_I2C_RDATA_ACK = 9'b100000000
  } fc_i2c_state_t;
  typedef enum logic [1:0] {
    FC_CHIP_SHUT = 2'b01,
    FC_CHIP_STANDBY = 2'b10
  } fc_chip_state_t;
  typedef enum logic [2:0] {
    FC_SINK_OFF = 3'b001,
    FC_SINK_TORCH = 3'b010,
    FC_SINK_FLASH = 3'b100
  } fc_sink_t;
endpackage

/* File: rtl/fc_timer_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface fc_timer_if #(parameter int CNT_W = 24);
  logic restart;
  logic run;
  logic [CNT_W-1:0] limit;
  logic expired;
  modport owner (output restart, output run, output limit, input expired);
  modport timer (input restart, input run, input limit, output expired);
endinterface
`default_nettype wire

/* File: rtl/fc_interval_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module fc_interval_timer #(
  parameter int CNT_W = 24
) (
  input wire logic mclk,
  input wire logic arst_n,
  fc_timer_if.timer tif
);
  logic [CNT_W-1:0] count;

  // counts while run, stops at the limit
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      count <= '0;
    else if (tif.restart || !tif.run)
      count <= '0;
    else if (count < tif.limit)
      count <= count + 1'b1;
  end

  assign tif.expired = tif.run && !tif.restart && (count >= tif.limit);
endmodule
`default_nettype wire

/* File: rtl/fc_mode_ctrl.sv */
// Contract
// R1: enable high keeps chip in standby
// R2: enable low over one second shuts down
// R3: register bit can enable or disable chip
// R4: chip-on bit acts like enable pin high
// R5: flash pin rising edge starts flash, timer
// R6: flash register request starts bounded flash
// R7: flash ends when pin low, request cleared
// R8: torch starts on pin edge or register
// R9: torch ends when pin low, request cleared
// R10: inhibit high drops flash to torch level
// R11: inhibit low restores flash level
// R12: inhibit works for pin or register flash
// R13: flash level is max times field percentage
// R14: torch level is max times field percentage
// R15: safety time-out switches flash off
// R16: time-out code steps 156.25 ms, default 111
// R17: current code 0000 full, 0111 is 44.7%
// R18: flash register holds time-out, request, current
// R19: over-voltage turns off boost and sinks
// R20: below threshold minus hysteresis resumes operation
// R21: open channel detected, other channel keeps running
// R22: safety timer restarts per flash, stops after
`timescale 1ns/10ps
`default_nettype none
`include "fc_regs.svh"
module fc_mode_ctrl #(
  parameter int CNT_W = 24,
  parameter int ENABLE_LOW_CYCLES = `FC_ENABLE_LOW_MS * `FC_CLK_KHZ,
  parameter int TMO_STEP_CYCLES =
    (`FC_TMO_STEP_US * `FC_CLK_KHZ) / `FC_US_PER_MS
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic chip_enable,
  input wire logic flash_request_pin,
  input wire logic torch_request_pin,
  input wire logic flash_inhibit_input,
  input wire logic ov_above_threshold,
  input wire logic ov_below_hysteresis,
  input wire logic channel_one_open,
  input wire logic channel_two_open,
  output logic chip_standby,
  output logic boost_enable,
  output fc_pkg::fc_sink_t channel_one_sink,
  output fc_pkg::fc_sink_t channel_two_sink,
  output logic [9:0] channel_one_permille,
  output logic [9:0] channel_two_permille
);
  import fc_pkg::*;

  generate
    if (ENABLE_LOW_CYCLES < 1 || TMO_STEP_CYCLES < 1 ||
        ENABLE_LOW_CYCLES >= 2 ** CNT_W ||
        TMO_STEP_CYCLES * `FC_TMO_CODES >= 2 ** CNT_W)
    begin : g_bad_counts
      $error("timer width cannot hold the configured counts");
    end
  endgenerate

  localparam logic [CNT_W-1:0] LOW_LIMIT = CNT_W'(ENABLE_LOW_CYCLES);
  localparam logic [CNT_W-1:0] STEP_C = CNT_W'(TMO_STEP_CYCLES);

  function automatic logic [9:0] fc_permille(input logic [3:0] code);
    case (code)
      4'h0: fc_permille = 10'h3E8;
      4'h1: fc_permille = 10'h384;
      4'h2: fc_permille = 10'h320;
      4'h3: fc_permille = 10'h2BC;
      4'h4: fc_permille = 10'h276;
      4'h5: fc_permille = 10'h230;
      4'h6: fc_permille = 10'h1F4;
      default: fc_permille = 10'h1BF;
    endcase
  endfunction

  // two-stage synchronisers for all asynchronous pins
  logic [`FC_NUM_PINS-1:0] pin_raw;
  logic [`FC_NUM_PINS-1:0] pin_meta;
  logic [`FC_NUM_PINS-1:0] pin_s;
  // bus lines rest high, so no false edge follows reset
  localparam logic [`FC_NUM_PINS-1:0] PIN_IDLE = `FC_PIN_IDLE;
  assign pin_raw = {scl, sda_in, chip_enable, flash_request_pin,
                    torch_request_pin, flash_inhibit_input,
                    ov_above_threshold, ov_below_hysteresis,
                    channel_one_open, channel_two_open};
  genvar gi;
  generate
    for (gi = 0; gi < `FC_NUM_PINS; gi++)
    begin : g_sync
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          pin_meta[gi] <= PIN_IDLE[gi];
          pin_s[gi] <= PIN_IDLE[gi];
        end
        else
        begin
          pin_meta[gi] <= pin_raw[gi];
          pin_s[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic scl_s, sda_s, en_s, fpin_s, tpin_s, inh_s;
  logic ova_s, ovb_s;
  logic [1:0] open_s;
  assign {scl_s, sda_s, en_s, fpin_s, tpin_s, inh_s, ova_s, ovb_s,
          open_s[0], open_s[1]} = pin_s;

  // edge detection on synchronised levels
  logic scl_d, sda_d, fpin_d, tpin_d;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      fpin_d <= 1'b0;
      tpin_d <= 1'b0;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      fpin_d <= fpin_s;
      tpin_d <= tpin_s;
    end
  end

  logic scl_rise, scl_fall, i2c_start, i2c_stop, flash_rise, torch_rise;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign i2c_start = scl_s && scl_d && sda_d && !sda_s;
  assign i2c_stop = scl_s && scl_d && !sda_d && sda_s;
  assign flash_rise = fpin_s && !fpin_d;
  assign torch_rise = tpin_s && !tpin_d;

  // serial register port
  fc_i2c_state_t i2c_state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [2:0] reg_ptr;
  logic rw_read, master_ack;
  logic [7:0] master_reg, flash_settings, torch_settings, rd_data;
  logic reg_wr, led_open;

  always_comb
  begin
    case (reg_ptr)
      `FC_ADDR_MASTER: rd_data = master_reg;
      `FC_ADDR_FLASH: rd_data = flash_settings;
      `FC_ADDR_TORCH: rd_data = torch_settings;
      default: rd_data = 8'h00;
    endcase
  end

  assign reg_wr = scl_fall && !i2c_start && !i2c_stop &&
                  (i2c_state == FC_I2C_WDATA) && (bit_cnt == `FC_BYTE_BITS);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      i2c_state <= FC_I2C_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      reg_ptr <= 3'h0;
      rw_read <= 1'b0;
      master_ack <= 1'b0;
    end
    else if (i2c_start)
    begin
      i2c_state <= FC_I2C_ADDR;
      bit_cnt <= 4'h0;
    end
    else if (i2c_stop)
      i2c_state <= FC_I2C_IDLE;
    else if (scl_rise)
    begin
      if (i2c_state == FC_I2C_ADDR || i2c_state == FC_I2C_REG ||
          i2c_state == FC_I2C_WDATA)
      begin
        shift <= {shift[6:0], sda_s};
        bit_cnt <= bit_cnt + 1'b1;
      end
      else if (i2c_state == FC_I2C_RDATA)
        bit_cnt <= bit_cnt + 1'b1;
      else if (i2c_state == FC_I2C_RDATA_ACK)
        master_ack <= !sda_s;
    end
    else if (scl_fall)
    begin
      case (i2c_state)
        FC_I2C_ADDR:
          if (bit_cnt == `FC_BYTE_BITS)
          begin
            if (shift[7:1] == `FC_SLAVE_ADDR)
            begin
              i2c_state <= FC_I2C_ADDR_ACK;
              rw_read <= shift[0];
            end
            else
              i2c_state <= FC_I2C_IDLE;
          end
        FC_I2C_ADDR_ACK:
        begin
          bit_cnt <= 4'h0;
          if (rw_read)
          begin
            i2c_state <= FC_I2C_RDATA;
            shift <= rd_data;
          end
          else
            i2c_state <= FC_I2C_REG;
        end
        FC_I2C_REG:
          if (bit_cnt == `FC_BYTE_BITS)
          begin
            i2c_state <= FC_I2C_REG_ACK;
            reg_ptr <= shift[2:0];
          end
        FC_I2C_REG_ACK:
        begin
          bit_cnt <= 4'h0;
          i2c_state <= FC_I2C_WDATA;
        end
        FC_I2C_WDATA:
          if (bit_cnt == `FC_BYTE_BITS)
            i2c_state <= FC_I2C_WDATA_ACK;
        FC_I2C_WDATA_ACK:
        begin
          bit_cnt <= 4'h0;
          reg_ptr <= reg_ptr + 1'b1;
          i2c_state <= FC_I2C_WDATA;
        end
        FC_I2C_RDATA:
          if (bit_cnt == `FC_BYTE_BITS)
          begin
            i2c_state <= FC_I2C_RDATA_ACK;
            reg_ptr <= reg_ptr + 1'b1;
          end
          else
            shift <= {shift[6:0], 1'b0};
        FC_I2C_RDATA_ACK:
        begin
          bit_cnt <= 4'h0;
          if (master_ack)
          begin
            i2c_state <= FC_I2C_RDATA;
            shift <= rd_data;
          end
          else
            i2c_state <= FC_I2C_IDLE;
        end
        default: i2c_state <= FC_I2C_IDLE;
      endcase
    end
  end

  // open-drain data line: acknowledge and read bits
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      sda_oe_n <= 1'b1;
    else
      sda_oe_n <= !(i2c_state == FC_I2C_ADDR_ACK ||
                    i2c_state == FC_I2C_REG_ACK ||
                    i2c_state == FC_I2C_WDATA_ACK ||
                    (i2c_state == FC_I2C_RDATA && !shift[7]));
  end
  assign sda_out = 1'b0;

  // register file
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      master_reg <= `FC_RST_MASTER;
      flash_settings <= `FC_RST_FLASH; // R16
      torch_settings <= `FC_RST_TORCH;
    end
    else
    begin
      master_reg <= 8'h00;
      master_reg[`FC_BIT_ON] <= master_reg[`FC_BIT_ON];
      master_reg[`FC_BIT_OPEN] <= led_open;
      if (reg_wr && reg_ptr == `FC_ADDR_MASTER)
        master_reg[`FC_BIT_ON] <= shift[`FC_BIT_ON]; // R3
      if (reg_wr && reg_ptr == `FC_ADDR_FLASH)
        flash_settings <= shift; // R18
      if (reg_wr && reg_ptr == `FC_ADDR_TORCH)
        torch_settings <= shift;
    end
  end

  // chip enable and shutdown
  fc_chip_state_t chip_state;
  logic en_eff, ready, ovp_trip;
  fc_timer_if #(.CNT_W(CNT_W)) low_tif ();
  fc_timer_if #(.CNT_W(CNT_W)) tmo_tif ();
  assign en_eff = en_s || master_reg[`FC_BIT_ON]; // R4
  assign low_tif.restart = en_eff;
  assign low_tif.run = !en_eff && (chip_state == FC_CHIP_STANDBY); // R2
  assign low_tif.limit = LOW_LIMIT;
  fc_interval_timer #(.CNT_W(CNT_W)) u_low_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .tif(low_tif)
  );

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      chip_state <= FC_CHIP_SHUT;
    else
      case (chip_state)
        FC_CHIP_SHUT:
          if (en_eff)
            chip_state <= FC_CHIP_STANDBY; // R1
        FC_CHIP_STANDBY:
          if (low_tif.expired)
            chip_state <= FC_CHIP_SHUT; // R2
        default: chip_state <= FC_CHIP_SHUT;
      endcase
  end

  // over-voltage latch with hysteresis
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      ovp_trip <= 1'b0;
    else if (ova_s)
      ovp_trip <= 1'b1; // R19
    else if (ovb_s)
      ovp_trip <= 1'b0; // R20
  end

  assign ready = (chip_state == FC_CHIP_STANDBY) && !ovp_trip;

  // flash and torch modes
  logic flash_on, torch_on, flash_start, torch_start, inhibit;
  logic [CNT_W-1:0] tmo_units;
  assign flash_start = ready && (flash_rise || // R5
    (reg_wr && reg_ptr == `FC_ADDR_FLASH && shift[`FC_BIT_FLASH_REQ])); // R6
  assign torch_start = ready && (torch_rise || // R8
    (reg_wr && reg_ptr == `FC_ADDR_TORCH && shift[`FC_BIT_TORCH_REQ]));
  assign tmo_units = CNT_W'(flash_settings[`FC_TMO_HI:`FC_TMO_LO]) + 1'b1;
  assign tmo_tif.limit = tmo_units * STEP_C - 1'b1; // R16
  assign tmo_tif.restart = flash_start; // R22
  assign tmo_tif.run = flash_on; // R22
  fc_interval_timer #(.CNT_W(CNT_W)) u_tmo_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .tif(tmo_tif)
  );

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      flash_on <= 1'b0;
    else if (!ready)
      flash_on <= 1'b0;
    else if (flash_start)
      flash_on <= 1'b1;
    else if (tmo_tif.expired)
      flash_on <= 1'b0; // R15
    else if (!fpin_s && !flash_settings[`FC_BIT_FLASH_REQ])
      flash_on <= 1'b0; // R7
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      torch_on <= 1'b0;
    else if (!ready)
      torch_on <= 1'b0;
    else if (torch_start)
      torch_on <= 1'b1;
    else if (!tpin_s && !torch_settings[`FC_BIT_TORCH_REQ])
      torch_on <= 1'b0; // R9
  end

  // sink level selection
  fc_sink_t level_mode;
  logic [9:0] level_pm;
  assign inhibit = inh_s || torch_settings[`FC_BIT_TORCH_INH]; // R12
  always_comb
  begin
    level_mode = FC_SINK_OFF;
    level_pm = 10'h000;
    if (flash_on && !inhibit)
    begin
      level_mode = FC_SINK_FLASH; // R11
      level_pm = fc_permille(flash_settings[`FC_CUR_HI:`FC_CUR_LO]); // R13
    end
    else if (flash_on || torch_on)
    begin
      level_mode = FC_SINK_TORCH; // R10
      level_pm = fc_permille(torch_settings[`FC_CUR_HI:`FC_CUR_LO]); // R14
    end
  end

  fc_sink_t sink_q [2];
  logic [9:0] pm_q [2];
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          sink_q[gi] <= FC_SINK_OFF;
          pm_q[gi] <= 10'h000;
        end
        else if (!ready || open_s[gi]) // R19 R21
        begin
          sink_q[gi] <= FC_SINK_OFF;
          pm_q[gi] <= 10'h000;
        end
        else
        begin
          sink_q[gi] <= level_mode;
          pm_q[gi] <= level_pm; // R17
        end
      end
    end
  endgenerate

  assign channel_one_sink = sink_q[0];
  assign channel_two_sink = sink_q[1];
  assign channel_one_permille = pm_q[0];
  assign channel_two_permille = pm_q[1];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chip_standby <= 1'b0;
      boost_enable <= 1'b0;
      led_open <= 1'b0;
    end
    else
    begin
      chip_standby <= chip_state == FC_CHIP_STANDBY;
      boost_enable <= ready && (flash_on || torch_on) && !(&open_s); // R19
      led_open <= (flash_on || torch_on) && (&open_s); // R21
    end
  end
endmodule
`default_nettype wire

/* File: testbench/fc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module fc_host (
  output logic scl,
  output logic sda_drive,
  input wire logic sda
);
  // both lines released (pull-up high) outside frames
  initial
  begin
    scl = 1'b1;
    sda_drive = 1'b1;
  end
  task automatic start();
    sda_drive = 1'b1;
    #400 scl = 1'b1;
    #400 sda_drive = 1'b0;
    #400 scl = 1'b0;
    #200;
  endtask
  task automatic stop();
    sda_drive = 1'b0;
    #400 scl = 1'b1;
    #400 sda_drive = 1'b1;
    #400;
  endtask
  // data set mid low phase, sampled at end of high phase
  task automatic bitx(input logic b, output logic r);
    sda_drive = b;
    #200 scl = 1'b1;
    #400 r = sda;
    scl = 1'b0;
    #200;
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack,
    output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r[i]);
    bitx(mack, ack);
  endtask
endmodule
`default_nettype wire

/* File: testbench/fc_mode_ctrl_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module fc_mode_ctrl_assertions #(
  parameter int ENABLE_LOW_CYCLES = 50,
  parameter int TMO_STEP_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic chip_enable,
  input wire logic flash_inhibit_input,
  input wire logic ov_above_threshold,
  input wire logic ov_below_hysteresis,
  input wire logic channel_one_open,
  input wire logic chip_standby,
  input wire logic boost_enable,
  input wire fc_pkg::fc_sink_t channel_one_sink,
  input wire fc_pkg::fc_sink_t channel_two_sink
);
  import fc_pkg::*;
  int low_cnt;
  int flash_cnt;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // cycles the enable pin has been low
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      low_cnt <= 0;
    else if (chip_enable)
      low_cnt <= 0;
    else if (low_cnt < ENABLE_LOW_CYCLES + 8)
      low_cnt <= low_cnt + 1;
  // cycles a sink has stayed at flash level
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      flash_cnt <= 0;
    else if (channel_one_sink == FC_SINK_FLASH ||
      channel_two_sink == FC_SINK_FLASH)
      flash_cnt <= flash_cnt + 1;
    else
      flash_cnt <= 0;
  sequence s_enabled;
    (chip_enable && ov_below_hysteresis && !ov_above_threshold) [*6];
  endsequence
  sequence s_ov_held;
    ov_above_threshold [*6];
  endsequence
  a_standby_on_enable: assert property (s_enabled |-> chip_standby)
    else $error("standby missing while enabled");
  a_shutdown_delay: assert property (
    $fell(chip_standby) |-> low_cnt >= ENABLE_LOW_CYCLES)
    else $error("shutdown before enable low time");
  a_sda_open_drain: assert property (
    $changed(sda_oe_n) |-> !$past(scl) && !sda_out)
    else $error("data line moved while clock high");
  a_flash_in_standby: assert property (
    $rose(channel_one_sink == FC_SINK_FLASH) |-> chip_standby)
    else $error("flash while shut down");
  a_inhibit_drops: assert property (
    flash_inhibit_input [*6] |-> channel_one_sink != FC_SINK_FLASH)
    else $error("flash level under inhibit");
  a_timeout_bound: assert property (
    flash_cnt <= 8 * TMO_STEP_CYCLES)
    else $error("flash beyond longest time-out");
  a_ovp_all_off: assert property (s_ov_held |->
    channel_one_sink == FC_SINK_OFF && channel_two_sink == FC_SINK_OFF &&
    !boost_enable)
    else $error("sinks or boost on in over-voltage");
  a_open_channel_off: assert property (
    channel_one_open [*6] |-> channel_one_sink == FC_SINK_OFF)
    else $error("open channel still sinking");
endmodule
bind fc_mode_ctrl fc_mode_ctrl_assertions #(
  .ENABLE_LOW_CYCLES(ENABLE_LOW_CYCLES),
  .TMO_STEP_CYCLES(TMO_STEP_CYCLES)
) fc_mode_ctrl_assertions_inst (
  .mclk, .arst_n, .scl, .sda_out, .sda_oe_n, .chip_enable,
  .flash_inhibit_input,
  .ov_above_threshold, .ov_below_hysteresis, .channel_one_open,
  .chip_standby, .boost_enable, .channel_one_sink, .channel_two_sink
);
`default_nettype wire

/* File: testbench/flash_torch_mode_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_torch_mode_control_test;
  import fc_pkg::*;
  localparam int LOWC = 50;
  localparam int STEP = 20;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic en = 1'b0, fpin = 1'b0, tpin = 1'b0, inh = 1'b0;
  logic ov_hi = 1'b0, ov_lo = 1'b1, open1 = 1'b0, open2 = 1'b0;
  logic sda_out, sda_oe_n, standby, boost;
  fc_sink_t s1, s2;
  logic [9:0] p1, p2;
  wire logic scl, host_sda, sda_in;
  int n_errors = 0;
  int comparisons = 0;
  assign sda_in = host_sda & (sda_oe_n | sda_out);
  always #50 mclk = ~mclk;
  fc_host fc_host_inst (.scl(scl), .sda_drive(host_sda), .sda(sda_in));
  fc_mode_ctrl #(.ENABLE_LOW_CYCLES(LOWC), .TMO_STEP_CYCLES(STEP))
    fc_mode_ctrl_inst (.mclk(mclk), .arst_n(arst_n), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .chip_enable(en), .flash_request_pin(fpin), .torch_request_pin(tpin),
    .flash_inhibit_input(inh), .ov_above_threshold(ov_hi),
    .ov_below_hysteresis(ov_lo), .channel_one_open(open1),
    .channel_two_open(open2), .chip_standby(standby), .boost_enable(boost),
    .channel_one_sink(s1), .channel_two_sink(s2),
    .channel_one_permille(p1), .channel_two_permille(p2));
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // per-mille of full scale for a current code
  function automatic logic [15:0] pm(input logic [3:0] c);
    int t [8] = '{1000, 900, 800, 700, 630, 560, 500, 447};
    return 16'(t[c[3] ? 3'h7 : c[2:0]]);
  endfunction
  task automatic send(input logic [7:0] d);
    logic [7:0] r;
    logic k;
    fc_host_inst.xfer(d, 1'b1, r, k);
    check("ack", 16'(k), 16'h0000);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    fc_host_inst.start();
    send(8'hB4);
    send({5'h00, a});
    send(d);
    fc_host_inst.stop();
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    logic k;
    fc_host_inst.start();
    send(8'hB4);
    send({5'h00, a});
    fc_host_inst.start();
    send(8'hB5);
    fc_host_inst.xfer(8'hFF, 1'b1, d, k);
    fc_host_inst.stop();
  endtask
  task automatic wait_s1(input fc_sink_t e, input int lim, output int n);
    n = 0;
    while (s1 !== e && n < lim)
    begin
      cyc(1);
      n++;
    end
    if (s1 !== e)
    begin
      n_errors++;
      finish_test();
    end
  endtask
  initial
  begin
    logic [7:0] d;
    logic [3:0] fc, tc;
    logic k;
    int n;
    void'($urandom(32'h9DFC));
    cyc(12);
    arst_n = 1'b1;
    cyc(3);
    for (int a = 0; a < 3; a++)
    begin
      rd(3'(a), d);
      check("reset value", 16'(d), a == 1 ? 16'h00E0 : 16'h0000);
    end
    fpin = 1'b1;
    cyc(8);
    check("flash while shut", 16'(s1), 16'(FC_SINK_OFF));
    fpin = 1'b0;
    en = 1'b1;
    cyc(6);
    check("standby", 16'(standby), 16'h0001);
    fc = 4'($urandom_range(7));
    tc = 4'($urandom_range(15));
    wr(3'h1, {3'h7, 1'b0, fc});
    wr(3'h2, {4'h0, tc});
    fpin = 1'b1;
    wait_s1(FC_SINK_FLASH, 10, n);
    check("flash level", 16'(p2), pm(fc));
    inh = 1'b1;
    cyc(6);
    check("inhibit sink", 16'(s2), 16'(FC_SINK_TORCH));
    check("inhibit level", 16'(p1), pm(tc));
    inh = 1'b0;
    cyc(6);
    check("restore sink", 16'(s1), 16'(FC_SINK_FLASH));
    fpin = 1'b0;
    cyc(6);
    check("pin low off", 16'(s1), 16'(FC_SINK_OFF));
    for (int c = 0; c < 8; c++)
    begin
      fc = 4'($urandom_range(15));
      wr(3'h1, {3'(c), 1'b0, fc});
      fpin = 1'b1;
      wait_s1(FC_SINK_FLASH, 10, n);
      check("code level", 16'(p1), pm(fc));
      wait_s1(FC_SINK_OFF, 200, n);
      check("time-out", 16'(n), 16'((c + 1) * STEP));
      fpin = 1'b0;
      cyc(4);
    end
    wr(3'h1, {3'h7, 1'b1, fc});
    check("reg flash", 16'(s1), 16'(FC_SINK_FLASH));
    inh = 1'b1;
    cyc(6);
    check("reg inhibit", 16'(s1), 16'(FC_SINK_TORCH));
    inh = 1'b0;
    wait_s1(FC_SINK_OFF, 8 * STEP + 2, n);
    tc = 4'($urandom_range(15));
    wr(3'h2, {4'h1, tc});
    cyc(4);
    check("torch reg", 16'(s1), 16'(FC_SINK_TORCH));
    check("torch level", 16'(p2), pm(tc));
    wr(3'h2, {4'h0, tc});
    cyc(4);
    check("torch cleared", 16'(s1), 16'(FC_SINK_OFF));
    tpin = 1'b1;
    open1 = 1'b1;
    cyc(8);
    check("open channel", 16'(s1), 16'(FC_SINK_OFF));
    check("other channel", 16'(s2), 16'(FC_SINK_TORCH));
    open1 = 1'b0;
    ov_hi = 1'b1;
    ov_lo = 1'b0;
    cyc(8);
    check("ovp sink", 16'(s2), 16'(FC_SINK_OFF));
    check("ovp boost", 16'(boost), 16'h0000);
    ov_hi = 1'b0;
    ov_lo = 1'b1;
    tpin = 1'b0;
    cyc(6);
    tpin = 1'b1;
    cyc(8);
    check("resume", 16'(s2), 16'(FC_SINK_TORCH));
    check("resume boost", 16'(boost), 16'h0001);
    tpin = 1'b0;
    cyc(6);
    check("torch pin low", 16'(s2), 16'(FC_SINK_OFF));
    tpin = 1'b1;
    open1 = 1'b1;
    open2 = 1'b1;
    cyc(8);
    check("both open boost", 16'(boost), 16'h0000);
    rd(3'h0, d);
    check("open status", 16'(d), 16'h0002);
    tpin = 1'b0;
    open1 = 1'b0;
    open2 = 1'b0;
    cyc(6);
    fc_host_inst.start();
    send(8'hB4);
    send(8'h01);
    send({3'h7, 1'b0, fc});
    send({4'h8, tc});
    fc_host_inst.stop();
    fpin = 1'b1;
    cyc(8);
    check("reg inhibit bit", 16'(s1), 16'(FC_SINK_TORCH));
    check("reg inhibit level", 16'(p2), pm(tc));
    fc_host_inst.start();
    send(8'hB4);
    send(8'h01);
    fc_host_inst.start();
    send(8'hB5);
    fc_host_inst.xfer(8'hFF, 1'b0, d, k);
    check("burst read one", 16'(d), 16'({3'h7, 1'b0, fc}));
    fc_host_inst.xfer(8'hFF, 1'b1, d, k);
    check("burst read two", 16'({k, d}), 16'({1'b1, 4'h8, tc}));
    fc_host_inst.stop();
    fpin = 1'b0;
    en = 1'b0;
    cyc(LOWC / 2);
    en = 1'b1;
    cyc(2);
    check("short low", 16'(standby), 16'h0001);
    en = 1'b0;
    cyc(LOWC + 8);
    check("shutdown", 16'(standby), 16'h0000);
    wr(3'h0, 8'hFF);
    cyc(4);
    check("on bit", 16'(standby), 16'h0001);
    rd(3'h0, d);
    check("master reg", 16'(d), 16'h0008);
    wr(3'h0, 8'h00);
    cyc(LOWC + 8);
    check("off bit", 16'(standby), 16'h0000);
    wr(3'h5, 8'hA5);
    rd(3'h5, d);
    check("unmapped", 16'(d), 16'h0000);
    fc_host_inst.start();
    fc_host_inst.xfer(8'hC0, 1'b1, d, k);
    fc_host_inst.stop();
    check("foreign address", 16'(k), 16'h0001);
    finish_test();
  end
endmodule
`default_nettype wire
